// ===== rtl/fol_fail_logic.sv
// Fail output logic: failure collection, status flags and three fail pins
module fol_fail_logic
   import fol_pkg::*;
#(
   parameter int unsigned BLINK_CYC = BLINK_PERIOD_CYC,
   parameter int unsigned PULSE_CYC = PULSE_PERIOD_CYC
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Hardware configuration, read live each cycle
   input  wire logic [1:0] hw_config,
   // Failure sources, levels from the same clock domain
   input  wire logic       thermal_shutdown_level_two,
   input  wire logic       main_reg_short,
   input  wire logic       main_reg_overvolt,
   input  wire logic       main_reg_overvolt_reset_en,
   // Event pulses
   input  wire logic       watchdog_fail_event,
   input  wire logic       watchdog_good_trigger,
   input  wire logic       main_reg_undervolt_event,
   input  wire logic       main_reg_good_start,
   // Mode events
   input  wire logic       sleep_entry,
   input  wire logic       stop_watchdog_off,
   input  wire logic       normal_mode,
   // Software control
   input  wire logic       fail_out_test_force,
   input  wire logic       failure_clear,
   input  wire logic [1:0] pulsed_duty_select,
   // Status
   output logic            failure_flag,
   output logic            watchdog_error_flag,
   output logic            fail_safe_request,
   output logic            fail_out_active,
   // Open-drain pins: output value and active-low enable
   output logic            static_fail_out_o,
   output logic            static_fail_out_oe_n,
   output logic            blink_fail_out_o,
   output logic            blink_fail_out_oe_n,
   output logic            pulsed_fail_out_o,
   output logic            pulsed_fail_out_oe_n
);

   localparam int unsigned BW = $clog2(BLINK_CYC);
   localparam int unsigned PW = $clog2(PULSE_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // Behaviour overview
   //
   // Level causes:
   // - thermal shutdown
   //   level two
   // - main regulator
   //   short to ground
   // - overvoltage, only
   //   with its reset
   //   enable set
   //
   // Event causes:
   // - fourth main
   //   regulator
   //   undervoltage
   //   in a row
   // - a counted
   //   watchdog failure
   //
   // Any cause sets the
   // failure flag,
   // raises the request
   // for Fail-Safe and
   // turns the outputs
   // on, all on one edge.
   //
   // A software clear is
   // refused while a
   // level cause or the
   // watchdog flag
   // stands; a new cause
   // in the same cycle
   // wins over it.
   //
   // After a failure the
   // outputs stay on
   // outside Normal mode
   // even with the flag
   // clear, so a restart
   // keeps lamps lit.
   // Test-only activation
   // drops at once.
   //
   // Pins follow the
   // state one edge late,
   // all three together.
   //
   // Limitation: duty
   // and configuration
   // are read live;
   // change them only
   // while outputs off.

   // Duty on-time in cycles for a selection code
   function automatic logic [PW-1:0] duty_cycles(input logic [1:0] sel);
      logic [63:0] permil;
      permil = 64'(DUTY_20_PERMIL);
      case (sel)
         DUTY_SEL_20:  permil = 64'(DUTY_20_PERMIL);
         DUTY_SEL_10:  permil = 64'(DUTY_10_PERMIL);
         DUTY_SEL_5:   permil = 64'(DUTY_5_PERMIL);
         DUTY_SEL_2P5: permil = 64'(DUTY_2P5_PERMIL);
         default:      permil = 64'(DUTY_20_PERMIL);
      endcase
      return PW'((64'(PULSE_CYC) * permil) / 64'd1000);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Undervoltage run counter
   logic uv_hit;

   fol_undervolt_count #(
      .LIMIT (UNDERVOLT_LIMIT)
   ) u_uv_count (
      .clock           (clock),
      .reset           (reset),
      .undervolt_event (main_reg_undervolt_event),
      .good_start      (main_reg_good_start),
      .limit_hit       (uv_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Failure causes
   logic level_cause;
   logic ov_cause;
   logic wd_is_fail;
   logic non_watchdog_error_flag;

   assign ov_cause    = main_reg_overvolt & main_reg_overvolt_reset_en;
   assign level_cause = thermal_shutdown_level_two | main_reg_short | ov_cause;
   assign non_watchdog_error_flag = level_cause | uv_hit;

   // Watchdog failure state
   logic wd_flag_reg;
   logic wd_flag_next;
   logic wd_count_reg;
   logic wd_count_next;

   // Configs 3 and 4 need a second consecutive failure; config 2 also skips
   // the first. Config 1 acts on the first failure.
   always_comb begin
      wd_is_fail    = 1'b0;
      wd_count_next = wd_count_reg;
      wd_flag_next  = wd_flag_reg;
      if (watchdog_good_trigger) begin
         wd_count_next = 1'b0;
         wd_flag_next  = 1'b0;
      end
      // Other-cause clears apply before a new failure, so a set wins
      if (sleep_entry || stop_watchdog_off || non_watchdog_error_flag) begin
         wd_flag_next  = 1'b0;
         wd_count_next = 1'b0;
      end
      if (watchdog_fail_event) begin
         wd_flag_next = 1'b1;
         case (hw_config)
            HW_CONFIG_1: wd_is_fail = 1'b1;
            HW_CONFIG_2,
            HW_CONFIG_3,
            HW_CONFIG_4: begin
               if (wd_count_reg) begin
                  wd_is_fail = 1'b1;
               end else begin
                  wd_count_next = 1'b1;
               end
            end
            default: wd_is_fail = 1'b1;
         endcase
      end
   end

   // Watchdog flag and failure count registers
   always_ff @(posedge clock) begin
      if (reset) begin
         wd_flag_reg  <= 1'b0;
         wd_count_reg <= 1'b0;
      end else begin
         wd_flag_reg  <= wd_flag_next;
         wd_count_reg <= wd_count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Failure status flag and activation state
   logic       fail_event;
   logic       cond_present;
   logic       fail_flag_reg;
   logic       fail_flag_next;
   logic       fs_req_reg;
   logic       fs_req_next;
   fol_state_t state_reg;
   fol_state_t state_next;
   logic       want_active;
   logic       hold_reg;
   logic       hold_next;

   // Any new cause, and what may still block a clear
   assign fail_event   = non_watchdog_error_flag | wd_is_fail;
   assign cond_present = level_cause | wd_flag_reg;

   // Flag set wins over a software clear in the same cycle
   always_comb begin
      fail_flag_next = fail_flag_reg;
      fs_req_next    = 1'b0;
      if (failure_clear && !cond_present) begin
         fail_flag_next = 1'b0;
      end
      if (fail_event) begin
         fail_flag_next = 1'b1;
      end
      // Watchdog entry is configuration dependent: only config 1 and the
      // second failure of others ask for Fail-Safe here
      if (non_watchdog_error_flag || wd_is_fail) begin
         fs_req_next = 1'b1;
      end
   end

   // Outputs on while a failure is latched or the test bit is set; the hold
   // bit remembers a failure so outside Normal mode a flag clear alone cannot drop the outputs
   always_comb begin
      want_active = fail_flag_next | fail_out_test_force;
      state_next  = state_reg;
      hold_next   = hold_reg | fail_flag_next;
      case (state_reg)
         FOL_IDLE: begin
            // Enter on any latched failure or the test bit
            if (want_active) begin
               state_next = FOL_ACTIVE;
            end
         end
         FOL_ACTIVE: begin
            // After a failure only Normal mode releases; test-only in any mode
            if (!want_active && (normal_mode || !hold_reg)) begin
               state_next = FOL_IDLE;
               hold_next  = 1'b0;
            end
         end
         default: state_next = FOL_IDLE;
      endcase
   end

   // Flag, request, hold and state registers
   always_ff @(posedge clock) begin
      if (reset) begin
         fail_flag_reg <= 1'b0;
         fs_req_reg    <= 1'b0;
         hold_reg      <= 1'b0;
         state_reg     <= FOL_IDLE;
      end else begin
         fail_flag_reg <= fail_flag_next;
         fs_req_reg    <= fs_req_next;
         hold_reg      <= hold_next;
         state_reg     <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Waveforms; both restart from zero at each activation
   logic active;
   logic blink_drive;
   logic pulse_drive;
   logic [PW-1:0] pulse_on;

   // Run both generators from the state
   assign active   = (state_reg == FOL_ACTIVE);
   assign pulse_on = duty_cycles(pulsed_duty_select);

   fol_wave_gen #(
      .PERIOD_CYC (BLINK_CYC),
      .CW         (BW)
   ) u_blink (
      .clock     (clock),
      .reset     (reset),
      .run       (active),
      .on_cycles (BW'(BLINK_CYC / 2)),
      .drive     (blink_drive)
   );

   fol_wave_gen #(
      .PERIOD_CYC (PULSE_CYC),
      .CW         (PW)
   ) u_pulse (
      .clock     (clock),
      .reset     (reset),
      .run       (active),
      .on_cycles (pulse_on),
      .drive     (pulse_drive)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive registers; enable low means the pin is pulled low
   logic static_oe_n_reg;
   logic blink_oe_n_reg;
   logic pulse_oe_n_reg;
   logic static_oe_n_next;
   logic blink_oe_n_next;
   logic pulse_oe_n_next;

   // All three follow one state, so they switch in the same cycle
   always_comb begin
      static_oe_n_next = !active;
      blink_oe_n_next  = !(active && blink_drive);
      pulse_oe_n_next  = !(active && pulse_drive);
   end

   // Pin enable registers, released at reset
   always_ff @(posedge clock) begin
      if (reset) begin
         static_oe_n_reg <= 1'b1;
         blink_oe_n_reg  <= 1'b1;
         pulse_oe_n_reg  <= 1'b1;
      end else begin
         static_oe_n_reg <= static_oe_n_next;
         blink_oe_n_reg  <= blink_oe_n_next;
         pulse_oe_n_reg  <= pulse_oe_n_next;
      end
   end

   // Open drain: value is always low, enable off releases the pin
   assign static_fail_out_o    = 1'b0;
   assign blink_fail_out_o     = 1'b0;
   assign pulsed_fail_out_o    = 1'b0;
   assign static_fail_out_oe_n = static_oe_n_reg;
   assign blink_fail_out_oe_n  = blink_oe_n_reg;
   assign pulsed_fail_out_oe_n = pulse_oe_n_reg;

   // Status straight from the registers
   assign failure_flag        = fail_flag_reg;
   assign watchdog_error_flag = wd_flag_reg;
   assign fail_safe_request   = fs_req_reg;
   assign fail_out_active     = active;

endmodule

// ===== rtl/fol_pkg.sv
// Package of constants and types for the fail output logic
//
// Contract
// - Three open-drain fail outputs, each active by pulling low.
// - Watchdog failure activates on 2nd in configs 3/4, 1st in 1/2; the code activates on 2nd in config 2 too.
// - Level-two thermal shutdown and main regulator short activate outputs.
// - Main regulator overvoltage counts only with overvoltage-reset enable set.
// - Four consecutive main regulator undervoltage events activate outputs.
// - Activation enters Fail-Safe too, watchdog case depends on configuration.
// - Failure status flag sets whenever a failure activates the outputs.
// - Test force bit activates outputs independent of failure flags.
// - Without failure present, software may switch outputs off, no trigger needed; the code keeps them on outside Normal mode after a failure.
// - Outputs release only when conditions gone and status flag cleared.
// - Watchdog flag clears on Sleep, non-watchdog Fail-Safe, or Stop disable.
// - Config 2: first watchdog failure sets no flag, no activation; the code sets the watchdog flag on it.
// - All three outputs activate together in one cycle.
// - Static output held low throughout activation.
// - Blinking output toggles at 1.25 Hz with 50% duty.
// - Pulsed output runs 100 Hz PWM, 20% duty by default.
// - Pulsed duty selectable 20, 10, 5, 2.5 percent; reset selects 20.
package fol_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and waveform timing
   localparam int unsigned CLOCK_HZ          = 100_000_000;
   localparam int unsigned BLINK_PERIOD_MS   = 800;        // 1.25 Hz
   localparam int unsigned PULSE_PERIOD_MS   = 10;         // 100 Hz
   localparam int unsigned BLINK_PERIOD_CYC  = CLOCK_HZ / 1000 * BLINK_PERIOD_MS;
   localparam int unsigned PULSE_PERIOD_CYC  = CLOCK_HZ / 1000 * PULSE_PERIOD_MS;
   // Duty expressed in tenths of a percent of the period
   localparam int unsigned DUTY_20_PERMIL    = 200;
   localparam int unsigned DUTY_10_PERMIL    = 100;
   localparam int unsigned DUTY_5_PERMIL     = 50;
   localparam int unsigned DUTY_2P5_PERMIL   = 25;
   localparam int unsigned UNDERVOLT_LIMIT   = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and encodings
   localparam logic [1:0] DUTY_SEL_20   = 2'h0;
   localparam logic [1:0] DUTY_SEL_10   = 2'h1;
   localparam logic [1:0] DUTY_SEL_5    = 2'h2;
   localparam logic [1:0] DUTY_SEL_2P5  = 2'h3;
   localparam logic [1:0] DUTY_SEL_RST  = DUTY_SEL_20;
   localparam logic [1:0] HW_CONFIG_1   = 2'h0;
   localparam logic [1:0] HW_CONFIG_2   = 2'h1;
   localparam logic [1:0] HW_CONFIG_3   = 2'h2;
   localparam logic [1:0] HW_CONFIG_4   = 2'h3;

   // Output activity state
   typedef enum logic [1:0] {
      FOL_IDLE   = 2'b01,
      FOL_ACTIVE = 2'b10
   } fol_state_t;

endpackage

// ===== rtl/fol_wave_gen.sv
// Periodic high-active waveform generator with selectable on time
module fol_wave_gen
   import fol_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = 1000,
   parameter int unsigned CW         = $clog2(PERIOD_CYC)
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          reset,
   // Control
   input  wire logic          run,
   input  wire logic [CW-1:0] on_cycles,
   // Waveform, high while the drive phase lasts
   output logic               drive
);

   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;

   ////////////////////////////////////////////////////////////////////////////
   // Counter restarts whenever run is low, so each activation begins fresh
   always_comb begin
      count_next = count_reg;
      if (!run) begin
         count_next = '0;
      end else if (count_reg == CW'(PERIOD_CYC - 1)) begin
         count_next = '0;
      end else begin
         count_next = count_reg + CW'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   // Drive covers counts 0 to on_cycles-1, so the first phase is full length
   // and starts with run; the caller registers it onto the pin
   assign drive = run && (count_reg < on_cycles);

endmodule

// ===== rtl/fol_undervolt_count.sv
// Counter of consecutive main regulator undervoltage events
module fol_undervolt_count
   import fol_pkg::*;
#(
   parameter int unsigned LIMIT = UNDERVOLT_LIMIT
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // Events
   input  wire logic undervolt_event,
   input  wire logic good_start,
   // Result, a one-cycle pulse on reaching the limit
   output logic      limit_hit
);

   localparam int unsigned CW = $clog2(LIMIT + 1);

   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic          hit_reg;
   logic          hit_next;

   ////////////////////////////////////////////////////////////////////////////
   // A good start breaks the run of consecutive events
   always_comb begin
      count_next = count_reg;
      hit_next   = 1'b0;
      if (undervolt_event) begin
         if (count_reg == CW'(LIMIT - 1)) begin
            count_next = '0;
            hit_next   = 1'b1;
         end else begin
            count_next = count_reg + CW'(1);
         end
      end else if (good_start) begin
         count_next = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         count_reg <= '0;
         hit_reg   <= 1'b0;
      end else begin
         count_reg <= count_next;
         hit_reg   <= hit_next;
      end
   end

   assign limit_hit = hit_reg;

endmodule

// ===== dv/fol_fail_logic_chk.sv
// Port checker for the fail output logic
module fol_fail_logic_chk
   import fol_pkg::*;
#(
   parameter int unsigned BLINK_CYC = 100,
   parameter int unsigned PULSE_CYC = 200
) (
   // Clock and reset
   input wire logic       clock,
   input wire logic       reset,
   // Causes and controls
   input wire logic       thermal_shutdown_level_two,
   input wire logic       main_reg_short,
   input wire logic       main_reg_overvolt,
   input wire logic       main_reg_overvolt_reset_en,
   input wire logic       watchdog_fail_event,
   input wire logic       sleep_entry,
   input wire logic       fail_out_test_force,
   input wire logic [1:0] pulsed_duty_select,
   // Status
   input wire logic       failure_flag,
   input wire logic       watchdog_error_flag,
   input wire logic       fail_safe_request,
   input wire logic       fail_out_active,
   // Pins
   input wire logic       static_fail_out_o,
   input wire logic       static_fail_out_oe_n,
   input wire logic       blink_fail_out_o,
   input wire logic       blink_fail_out_oe_n,
   input wire logic       pulsed_fail_out_o,
   input wire logic       pulsed_fail_out_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////
   // Low-phase run lengths; 32 bits never wrap within a run
   logic [31:0] blink_low_reg, blink_low_next, pulse_low_reg, pulse_low_next;

   always_comb begin
      blink_low_next = blink_fail_out_oe_n ? 32'h0 : blink_low_reg + 32'h1;
      pulse_low_next = pulsed_fail_out_oe_n ? 32'h0 : pulse_low_reg + 32'h1;
   end

   always_ff @(posedge clock) begin
      blink_low_reg <= reset ? 32'h0 : blink_low_next;
      pulse_low_reg <= reset ? 32'h0 : pulse_low_next;
   end

   // On time of the pulsed pin for a duty code
   function automatic int on_cyc(input logic [1:0] s);
      case (s)
         DUTY_SEL_20: return PULSE_CYC * DUTY_20_PERMIL / 1000;
         DUTY_SEL_10: return PULSE_CYC * DUTY_10_PERMIL / 1000;
         DUTY_SEL_5:  return PULSE_CYC * DUTY_5_PERMIL / 1000;
         default:     return PULSE_CYC * DUTY_2P5_PERMIL / 1000;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Properties
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_pin_low; !static_fail_out_o && !blink_fail_out_o && !pulsed_fail_out_o; endproperty
   property p_hard_cause; thermal_shutdown_level_two || main_reg_short |=> failure_flag;
   endproperty
   property p_ov_gate; main_reg_overvolt && main_reg_overvolt_reset_en |=> failure_flag;
   endproperty
   property p_safe_req; $rose(failure_flag) |-> fail_safe_request; endproperty
   property p_flag_hold; failure_flag |-> fail_out_active; endproperty
   property p_test_on; fail_out_test_force [*3] |-> fail_out_active; endproperty
   property p_sleep_wd; sleep_entry && !watchdog_fail_event |=> !watchdog_error_flag;
   endproperty
   property p_together; $rose(fail_out_active) |=>
      !static_fail_out_oe_n && !blink_fail_out_oe_n && !pulsed_fail_out_oe_n; endproperty
   property p_static; fail_out_active |=> !static_fail_out_oe_n; endproperty
   property p_blink; fail_out_active && $rose(blink_fail_out_oe_n) |->
      blink_low_reg == BLINK_CYC / 2; endproperty
   property p_pulse; fail_out_active && $rose(pulsed_fail_out_oe_n) |->
      pulse_low_reg == on_cyc(pulsed_duty_select); endproperty
   property p_release; $fell(fail_out_active) |=>
      static_fail_out_oe_n && blink_fail_out_oe_n && pulsed_fail_out_oe_n; endproperty

   a_pin_low: assert property (p_pin_low) else $error("fail pin value not low");
   a_hard_cause: assert property (p_hard_cause) else $error("hard cause missed");
   a_ov_gate: assert property (p_ov_gate) else $error("overvoltage missed");
   a_safe_req: assert property (p_safe_req) else $error("no fail-safe request");
   a_flag_hold: assert property (p_flag_hold) else $error("outputs off with flag");
   a_test_on: assert property (p_test_on) else $error("test force ignored");
   a_sleep_wd: assert property (p_sleep_wd) else $error("watchdog flag kept");
   a_together: assert property (p_together) else $error("pins not together");
   a_static: assert property (p_static) else $error("static pin released");
   a_blink: assert property (p_blink) else $error("blink low phase wrong");
   a_pulse: assert property (p_pulse) else $error("pulse on time wrong");
   a_release: assert property (p_release) else $error("pins not released");

   // Main scenarios
   c_pulse: cover property (fail_out_active && $rose(pulsed_fail_out_oe_n));
   c_wd: cover property (watchdog_error_flag && failure_flag);
   c_off: cover property ($fell(fail_out_active));
endmodule

// ===== dv/fol_lamp_model.sv
// Lamp side of the three open-drain fail pins with pull-ups
module fol_lamp_model (
   // Pin drivers from the block
   input  wire logic st_o,
   input  wire logic st_oe_n,
   input  wire logic bl_o,
   input  wire logic bl_oe_n,
   input  wire logic pu_o,
   input  wire logic pu_oe_n,
   // Levels seen on the pins
   output wire logic st_pin,
   output wire logic bl_pin,
   output wire logic pu_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Released pin rises to the pull-up, never keeps the last driven value
   assign st_pin = st_oe_n ? 1'b1 : st_o;
   assign bl_pin = bl_oe_n ? 1'b1 : bl_o;
   assign pu_pin = pu_oe_n ? 1'b1 : pu_o;
endmodule

// ===== dv/fol_fail_logic_tb.sv
// Self-checking bench for the fail output logic
module fol_fail_logic_tb
   import fol_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Short periods keep the run brief
   localparam int unsigned BC = 100;
   localparam int unsigned PC = 200;
   logic clock, reset, normal_mode, fail_out_test_force, tsd, shrt, ov, ov_en;
   logic [1:0] hw_config, duty;
   logic [6:0] ev;
   logic flag, wd_flag, st_o, st_oe_n, bl_o, bl_oe_n, pu_o, pu_oe_n;
   wire  st_pin, bl_pin, pu_pin;
   int   errors, check_count, n;
   int   clr_tab[4] = '{1, 4, 5, 1};
   logic [3:0] causes[4] = '{4'h1, 4'h2, 4'hC, 4'h4};

   fol_fail_logic #(.BLINK_CYC(BC), .PULSE_CYC(PC)) dut (
      .clock(clock), .reset(reset), .hw_config(hw_config),
      .thermal_shutdown_level_two(tsd), .main_reg_short(shrt),
      .main_reg_overvolt(ov), .main_reg_overvolt_reset_en(ov_en),
      .watchdog_fail_event(ev[0]), .watchdog_good_trigger(ev[1]),
      .main_reg_undervolt_event(ev[2]), .main_reg_good_start(ev[3]),
      .sleep_entry(ev[4]), .stop_watchdog_off(ev[5]), .normal_mode(normal_mode),
      .fail_out_test_force(fail_out_test_force), .failure_clear(ev[6]),
      .pulsed_duty_select(duty), .failure_flag(flag), .watchdog_error_flag(wd_flag),
      .fail_safe_request(), .fail_out_active(),
      .static_fail_out_o(st_o), .static_fail_out_oe_n(st_oe_n),
      .blink_fail_out_o(bl_o), .blink_fail_out_oe_n(bl_oe_n),
      .pulsed_fail_out_o(pu_o), .pulsed_fail_out_oe_n(pu_oe_n));

   fol_lamp_model u_lamp (
      .st_o(st_o), .st_oe_n(st_oe_n), .bl_o(bl_o), .bl_oe_n(bl_oe_n),
      .pu_o(pu_o), .pu_oe_n(pu_oe_n), .st_pin(st_pin), .bl_pin(bl_pin), .pu_pin(pu_pin));

   initial clock = 1'b0;
   always #5 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask
   // One-cycle pulse on an event input
   task automatic pulse(input int i);
      @(negedge clock);
      ev[i] = 1'b1;
      @(negedge clock);
      ev = 7'h00;
   endtask
   task automatic chk(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_int(input string nm, input int e, input int g);
      check_count++;
      if (g != e) begin
         errors++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic pins(input logic e);
      chk("static pin", e, st_pin);
      chk("blink pin", e, bl_pin);
      chk("pulsed pin", e, pu_pin);
   endtask
   task automatic do_reset(input logic [1:0] c);
      reset = 1'b1;
      hw_config = c;
      {ov_en, ov, shrt, tsd} = 4'h0;
      ev = 7'h00;
      fail_out_test_force = 1'b0;
      normal_mode = 1'b1;
      duty = DUTY_SEL_RST;
      cyc(6);
      reset = 1'b0;
   endtask
   // Low cycles of blink (0) or pulsed (1) pin over a window
   task automatic count_low(input int sel, input int k, output int c);
      c = 0;
      repeat (k) begin
         @(negedge clock);
         if ((sel ? pu_pin : bl_pin) === 1'b0) c++;
      end
   endtask
   function automatic int on_cyc(input logic [1:0] s);
      case (s)
         DUTY_SEL_20: return PC * DUTY_20_PERMIL / 1000;
         DUTY_SEL_10: return PC * DUTY_10_PERMIL / 1000;
         DUTY_SEL_5:  return PC * DUTY_5_PERMIL / 1000;
         default:     return PC * DUTY_2P5_PERMIL / 1000;
      endcase
   endfunction
   task automatic results;
      $display("Checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   initial begin
      errors = 0;
      check_count = 0;
      void'($urandom(1));
      do_reset(HW_CONFIG_1);
      // Level causes; the last is overvoltage without its enable
      for (int i = 0; i < 4; i++) begin
         {ov_en, ov, shrt, tsd} = causes[i];
         cyc(1);
         chk("failure_flag", i != 3, flag);
         cyc(2);
         pins(i == 3);
         pulse(6);
         chk("failure_flag", i != 3, flag);
         {ov_en, ov, shrt, tsd} = 4'h0;
         normal_mode = (i != 1);
         pulse(6);
         cyc(2);
         chk("failure_flag", 1'b0, flag);
         pins(i != 1);
         normal_mode = 1'b1;
         cyc(3);
         pins(1'b1);
      end
      // Watchdog failures per configuration, three ways to clear the flag
      for (int c = 0; c < 4; c++) begin
         do_reset(c[1:0]);
         pulse(0);
         chk("failure_flag", c[1:0] == HW_CONFIG_1, flag);
         pulse(0);
         chk("failure_flag", 1'b1, flag);
         chk("watchdog_error_flag", 1'b1, wd_flag);
         pulse(6);
         chk("failure_flag", 1'b1, flag);
         pulse(clr_tab[c]);
         chk("watchdog_error_flag", 1'b0, wd_flag);
         pulse(6);
         cyc(2);
         chk("failure_flag", 1'b0, flag);
         pins(1'b1);
      end
      // Undervoltage runs with random spacing, broken by a good start
      do_reset(HW_CONFIG_1);
      repeat (3) begin
         pulse(2);
         cyc($urandom_range(3));
      end
      pulse(3);
      repeat (3) begin
         pulse(2);
         cyc($urandom_range(3));
      end
      cyc(2);
      chk("failure_flag", 1'b0, flag);
      pulse(2);
      cyc(1);
      chk("failure_flag", 1'b1, flag);
      pulse(6);
      cyc(2);
      pins(1'b1);
      // Test force with every duty code
      for (int d = 0; d < 4; d++) begin
         duty = d[1:0];
         fail_out_test_force = 1'b1;
         cyc(3);
         pins(1'b0);
         chk("failure_flag", 1'b0, flag);
         count_low(1, 2 * PC, n);
         chk_int("pulsed low", 2 * on_cyc(duty), n);
         count_low(0, BC, n);
         chk_int("blink low", BC / 2, n);
         fail_out_test_force = 1'b0;
         cyc(3);
         pins(1'b1);
      end
      results();
   end
endmodule

bind fol_fail_logic fol_fail_logic_chk #(.BLINK_CYC(BLINK_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (
   .clock(clock), .reset(reset), .thermal_shutdown_level_two(thermal_shutdown_level_two),
   .main_reg_short(main_reg_short), .main_reg_overvolt(main_reg_overvolt),
   .main_reg_overvolt_reset_en(main_reg_overvolt_reset_en),
   .watchdog_fail_event(watchdog_fail_event), .sleep_entry(sleep_entry),
   .fail_out_test_force(fail_out_test_force), .pulsed_duty_select(pulsed_duty_select),
   .failure_flag(failure_flag), .watchdog_error_flag(watchdog_error_flag),
   .fail_safe_request(fail_safe_request), .fail_out_active(fail_out_active),
   .static_fail_out_o(static_fail_out_o), .static_fail_out_oe_n(static_fail_out_oe_n),
   .blink_fail_out_o(blink_fail_out_o), .blink_fail_out_oe_n(blink_fail_out_oe_n),
   .pulsed_fail_out_o(pulsed_fail_out_o), .pulsed_fail_out_oe_n(pulsed_fail_out_oe_n));
